//--- smps_mode_ctrl.sv
// Mode and protection control unit with blanking timers, spike filters and APB registers.
`default_nettype none

// Functional notes
// - A 20 ms internal blanking count precedes burst entry and auto restart.
// - At blanking expiry release the clamp; gate restart on ramp done.
// - With both restart gate inputs true, wait 8 us then auto restart.
// - Blanking counter stays disabled throughout soft start.
// - Burst uses basic blanking only; restart adds the capacitor ramp.
// - Counter zero in normal; counts below 1.35 V; burst if still low.
// - Entering burst sets the burst flag and switches bias off.
// - Startup cell stays off throughout burst.
// - Burst wake above 3.61 V enables bias and switching with reduced limit.
// - Burst sleep at 3.0 V switches bias off again.
// - Feedback above 4.5 V in burst leaves burst, restoring full limit.
// - Map each fault to latched-off or auto-restart as listed.
// - Latched-off clears only when supply falls below 6.23 V.
// - Overvoltage needs supply above 24 V and feedback above 4.5 V.
// - While latched, lockout hysteresis alone runs the startup cell.
// - While latched, never start soft start or switching.
// - Thermal trip enters latched-off.
// - Thermal and overvoltage pass an 8 us spike filter first.
// - Winding fault above 1.66 V latches off immediately.
// - Extend pin pulled low requests latch, ignored 1 ms after startup.
// - Feedback above 4.5 V counts 20 ms, then releases the clamp.
// - Auto restart reruns startup with switching, rechecks faults.
// - Soft start lasts 20 ms and reruns at every restart attempt.
module smps_mode_ctrl
   import smps_ctrl_pkg::*;
#(
   parameter int BLANK_CYC = BLANK_CYC_DEF,
   parameter int SOFT_CYC = SOFT_CYC_DEF,
   parameter int LATCH_CYC = LATCH_CYC_DEF
) (
   input wire logic pclk,                 // Timebase clock, 50 MHz.
   input wire logic presetn,              // Power-on reset, active low.
   input wire logic psel,                 // APB select.
   input wire logic penable,              // APB enable.
   input wire logic pwrite,               // APB direction.
   input wire logic [ADDR_W-1:0] paddr,   // APB byte address.
   input wire logic [31:0] pwdata,        // APB write data.
   output logic [31:0] prdata,            // APB read data.
   output logic pready,                   // APB ready.
   output logic pslverr,                  // APB error for unmapped address.
   input wire comp_s comp,                // Raw comparator levels.
   output drive_s drive,                  // Bias, switching, limit, clamp, cell.
   output logic burst_flag                // High while in burst mode.
);

   localparam logic [LONG_W-1:0] BLANK_LIM = BLANK_CYC[LONG_W-1:0];
   localparam logic [LONG_W-1:0] SOFT_LIM = SOFT_CYC[LONG_W-1:0];
   localparam logic [LONG_W-1:0] LATCH_LIM = LATCH_CYC[LONG_W-1:0];

   comp_s c;
   mode_e state_r;
   mode_e state_nxt;
   drive_s drive_r;
   drive_s drive_nxt;
   logic burst_flag_r;
   logic [1:0] ctrl_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [LONG_W-1:0] blank_cnt;
   logic [LONG_W-1:0] soft_cnt;
   logic [LONG_W-1:0] latch_cnt;
   logic [SPIKE_W-1:0] ovp_cnt;
   logic [SPIKE_W-1:0] otp_cnt;
   logic [SPIKE_W-1:0] rst_cnt;
   logic blank_high_r;
   logic clamp_r;
   logic burst_on_r;
   logic cell_r;
   logic blank_run;
   logic blank_done;
   logic burst_go;
   logic restart_go;
   logic latch_trig;
   logic ext_armed;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Saturating step of a long delay counter; clears whenever run drops.
   function automatic logic [LONG_W-1:0] long_step(input logic [LONG_W-1:0] cnt,
                                                   input logic [LONG_W-1:0] lim,
                                                   input logic run);
      if (!run) begin
         return '0;
      end else if (cnt == lim) begin
         return cnt;
      end
      return cnt + 1'b1;
   endfunction : long_step

   // Saturating step of an 8 us spike filter; the filtered level is cnt == limit.
   function automatic logic [SPIKE_W-1:0] spike_step(input logic [SPIKE_W-1:0] cnt,
                                                     input logic run);
      if (!run) begin
         return '0;
      end else if (cnt == SPIKE_LIM) begin
         return cnt;
      end
      return cnt + 1'b1;
   endfunction : spike_step

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   // Comparators are analog and free running, so every one is synchronised.
   input_sync #(.W(COMP_W)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(comp),
      .dout(c)
   );

   // ----------------------------------------------------------------
   // Blanking timer and clamp switch
   // ----------------------------------------------------------------
   // Counts only in normal mode, which also keeps it idle during soft start.
   assign blank_run = (state_r == ST_NORMAL) &&
                      (c.fdbk_below_load || c.fdbk_above_max);
   assign blank_done = (blank_cnt == BLANK_LIM);

   // A change of cause restarts the count so one cause never inherits the other's time.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_cnt <= '0;
         blank_high_r <= 1'b0;
      end else begin
         blank_high_r <= c.fdbk_above_max;
         if (blank_high_r != c.fdbk_above_max) begin
            blank_cnt <= '0;
         end else begin
            blank_cnt <= long_step(blank_cnt, BLANK_LIM, blank_run);
         end
      end
   end

   // Burst entry takes the basic delay alone.
   assign burst_go = blank_done && !blank_high_r && c.fdbk_below_load &&
                     ctrl_r[CTRL_BURST_EN_BIT];

   // The clamp opens at expiry and closes again once overload clears.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clamp_r <= 1'b0;
      end else if (state_r != ST_NORMAL || !c.fdbk_above_max) begin
         clamp_r <= 1'b0;
      end else if (blank_done && blank_high_r) begin
         clamp_r <= 1'b1;
      end
   end

   // Restart gate: clamp released and extend pin ramped, then 8 us blanking.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt <= '0;
      end else begin
         rst_cnt <= spike_step(rst_cnt, clamp_r && c.ramp_done);
      end
   end
   assign restart_go = (rst_cnt == SPIKE_LIM);

   // ----------------------------------------------------------------
   // Latch-off detection
   // ----------------------------------------------------------------
   // Overvoltage is qualified by high feedback so small supply overshoots pass.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovp_cnt <= '0;
         otp_cnt <= '0;
      end else begin
         ovp_cnt <= spike_step(ovp_cnt, c.supply_over && c.fdbk_above_max);
         otp_cnt <= spike_step(otp_cnt, c.thermal_trip);
      end
   end

   // External requests are blanked for 1 ms after each startup.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_cnt <= '0;
      end else begin
         latch_cnt <= long_step(latch_cnt, LATCH_LIM,
                                state_r != ST_RESTART && state_r != ST_LATCHED);
      end
   end
   assign ext_armed = (latch_cnt == LATCH_LIM) && ctrl_r[CTRL_EXT_LATCH_BIT];

   // The winding fault bypasses any filter.
   assign latch_trig = (ovp_cnt == SPIKE_LIM) || (otp_cnt == SPIKE_LIM) ||
                       c.winding_fault || (ext_armed && c.latch_request);

   // ----------------------------------------------------------------
   // Soft start
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_cnt <= '0;
      end else begin
         soft_cnt <= long_step(soft_cnt, SOFT_LIM, state_r == ST_SOFT);
      end
   end

   // ----------------------------------------------------------------
   // Mode sequencing
   // ----------------------------------------------------------------
   // Latch requests outrank undervoltage, which outranks the normal flow.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RESTART: begin
            if (c.supply_above_off) begin
               state_nxt = ST_SOFT;
            end
         end
         ST_LATCHED: begin
            if (c.supply_below_reset) begin
               state_nxt = ST_RESTART;
            end
         end
         default: begin
            if (latch_trig) begin
               state_nxt = ST_LATCHED;
            end else if (c.supply_under || restart_go) begin
               state_nxt = ST_RESTART;
            end else if (state_r == ST_SOFT && soft_cnt == SOFT_LIM) begin
               state_nxt = ST_NORMAL;
            end else if (state_r == ST_NORMAL && burst_go) begin
               state_nxt = ST_BURST;
            end else if (state_r == ST_BURST && c.fdbk_above_max) begin
               state_nxt = ST_NORMAL;
            end
         end
      endcase
   end

   // Power-on waits like a restart for the supply to charge up.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_RESTART;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Burst bias follows wake and sleep; wake wins if both are seen.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_on_r <= 1'b0;
      end else if (state_r != ST_BURST) begin
         burst_on_r <= 1'b0;
      end else if (c.burst_wake) begin
         burst_on_r <= 1'b1;
      end else if (c.burst_sleep) begin
         burst_on_r <= 1'b0;
      end
   end

   // Lockout hysteresis for the startup cell while latched off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cell_r <= 1'b0;
      end else if (c.supply_below_on) begin
         cell_r <= 1'b1;
      end else if (c.supply_above_off) begin
         cell_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Drives lag the mode by one cycle, which is negligible against the analog loop.
   always_comb begin
      drive_nxt = '0;
      case (state_r)
         ST_SOFT: begin
            drive_nxt.bias_en = 1'b1;
            drive_nxt.switch_en = 1'b1;
         end
         ST_NORMAL: begin
            drive_nxt.bias_en = 1'b1;
            drive_nxt.switch_en = 1'b1;
            drive_nxt.clamp_release = clamp_r;
         end
         ST_BURST: begin
            drive_nxt.bias_en = burst_on_r;
            drive_nxt.switch_en = burst_on_r;
            drive_nxt.reduced_limit = 1'b1;
            drive_nxt.startup_cell = 1'b0;
         end
         ST_RESTART: begin
            drive_nxt.startup_cell = 1'b1;
         end
         default: begin
            drive_nxt.startup_cell = cell_r;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_r <= '0;
         burst_flag_r <= 1'b0;
      end else begin
         drive_r <= drive_nxt;
         burst_flag_r <= (state_r == ST_BURST);
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Read data and error are fixed in the setup cycle, so access is one cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else begin
         pready_r <= psel && !penable;
         if (psel && !penable) begin
            pslverr_r <= 1'b0;
            prdata_r <= '0;
            if (paddr == CTRL_OFF) begin
               prdata_r <= {30'h0, ctrl_r};
            end else if (paddr == STATUS_OFF) begin
               prdata_r <= status_s'{zero: '0, drive: drive_r, burst_flag: burst_flag_r,
                                     mode: state_r};
            end else begin
               pslverr_r <= 1'b1;
            end
         end
      end
   end

   // Writes to the status word are accepted and have no effect.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
      end else if (psel && penable && pready_r && pwrite && paddr == CTRL_OFF) begin
         ctrl_r <= pwdata[1:0];
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign drive = drive_r;
   assign burst_flag = burst_flag_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_wake;
      state_r == ST_BURST && c.burst_wake ##1 state_r == ST_BURST;
   endsequence

   sequence s_sleep;
      state_r == ST_BURST && c.burst_sleep && !c.burst_wake ##1 state_r == ST_BURST;
   endsequence

   a_burst_entry_blank: assert property (
      state_r == ST_NORMAL && state_nxt == ST_BURST
      |-> blank_cnt == BLANK_LIM && c.fdbk_below_load)
      else $error("Burst entered before the blanking count expired.");
   a_soft_blank_idle: assert property (
      state_r == ST_SOFT ##1 state_r == ST_SOFT |-> blank_cnt == '0)
      else $error("Blanking counter ran during soft start.");
   a_burst_bias_off: assert property (
      $rose(state_r == ST_BURST) |=> !drive_r.bias_en && burst_flag_r)
      else $error("Burst entry left bias on or flag clear.");
   a_burst_cell_off: assert property (
      state_r == ST_BURST |=> !drive_r.startup_cell)
      else $error("Startup cell on during burst.");
   a_burst_wake_limit: assert property (
      s_wake |=> drive_r.bias_en && drive_r.switch_en && drive_r.reduced_limit)
      else $error("Burst wake did not enable reduced-limit switching.");
   a_burst_sleep_off: assert property (
      s_sleep |=> !drive_r.bias_en)
      else $error("Burst sleep left bias on.");
   a_burst_exit_full: assert property (
      state_r == ST_BURST && c.fdbk_above_max |=> state_r != ST_BURST ##1 !drive_r.reduced_limit)
      else $error("High feedback did not leave burst.");
   a_latch_hold_only: assert property (
      state_r == ST_LATCHED && !c.supply_below_reset |=> state_r == ST_LATCHED)
      else $error("Latched-off cleared without supply reset.");
   a_latch_no_switch: assert property (
      state_r == ST_LATCHED |=> !drive_r.switch_en && !drive_r.bias_en)
      else $error("Switching while latched off.");
   a_restart_spike_wait: assert property (
      state_r == ST_NORMAL && state_nxt == ST_RESTART && !c.supply_under
      |-> $past(rst_cnt) == SPIKE_LIM - 1'b1 && clamp_r)
      else $error("Auto restart without the full spike wait.");
   a_winding_latch_now: assert property (
      (state_r == ST_NORMAL || state_r == ST_BURST) && c.winding_fault |=> state_r == ST_LATCHED)
      else $error("Winding fault did not latch off at once.");
   a_ext_latch_blank: assert property (
      state_r == ST_SOFT && latch_cnt != LATCH_LIM && !c.winding_fault && ovp_cnt != SPIKE_LIM
      && otp_cnt != SPIKE_LIM |=> state_r != ST_LATCHED)
      else $error("Latch request honoured inside the startup blank.");

endmodule : smps_mode_ctrl
`default_nettype wire

//--- smps_ctrl_pkg.sv
// Shared constants, types and register layout of the mode and protection controller.
`default_nettype none
package smps_ctrl_pkg;

   // ----------------------------------------------------------------
   // Timebase and delays
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_NS = 20;
   localparam int BLANK_MS = 20;
   localparam int SOFT_MS = 20;
   localparam int LATCH_BLANK_MS = 1;
   localparam int SPIKE_NS = 8000;
   localparam int BLANK_CYC_DEF = BLANK_MS * (CLK_HZ / 1000);
   localparam int SOFT_CYC_DEF = SOFT_MS * (CLK_HZ / 1000);
   localparam int LATCH_CYC_DEF = LATCH_BLANK_MS * (CLK_HZ / 1000);
   // A least time, so the count rounds up.
   localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int LONG_W = 21;
   localparam int SPIKE_W = 9;
   localparam logic [SPIKE_W-1:0] SPIKE_LIM = SPIKE_CYC[SPIKE_W-1:0];

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h04;
   localparam int CTRL_BURST_EN_BIT = 0;
   localparam int CTRL_EXT_LATCH_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ST_SOFT, ST_NORMAL, ST_BURST, ST_RESTART, ST_LATCHED} mode_e;

   // Comparator results, each high while its condition is true.
   typedef struct packed {
      logic fdbk_below_load;    // Feedback below 1.35 V.
      logic fdbk_above_max;     // Feedback above 4.5 V.
      logic ramp_done;          // Extend pin has ramped to 4.0 V.
      logic burst_wake;         // Feedback above 3.61 V.
      logic burst_sleep;        // Feedback at or below 3.0 V.
      logic supply_over;        // Supply above 24 V.
      logic winding_fault;      // Current sense peak above 1.66 V.
      logic thermal_trip;       // Junction above the trip temperature.
      logic latch_request;      // Extend pin pulled below 0.1 V.
      logic supply_below_on;    // Supply below 10.5 V.
      logic supply_above_off;   // Supply above 18 V.
      logic supply_below_reset; // Supply below 6.23 V.
      logic supply_under;       // Supply undervoltage while running.
   } comp_s;
   localparam int COMP_W = $bits(comp_s);

   typedef struct packed {
      logic bias_en;
      logic switch_en;
      logic reduced_limit;
      logic clamp_release;
      logic startup_cell;
   } drive_s;

   typedef struct packed {
      logic [22:0] zero;
      drive_s drive;
      logic burst_flag;
      mode_e mode;
   } status_s;

endpackage : smps_ctrl_pkg
`default_nettype wire

//--- input_sync.sv
// Three-stage synchroniser bank that passes a change once stages two and three agree.
`default_nettype none
module input_sync #(
   parameter int W = 1
) (
   input wire logic pclk,           // Timebase clock.
   input wire logic presetn,        // Asynchronous reset, active low.
   input wire logic [W-1:0] din,    // Asynchronous levels.
   output logic [W-1:0] dout        // Synchronised, agreed levels.
);

   logic [W-1:0] meta_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] out_r;

   // ----------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------
   // The first stage feeds only the second, so metastability never reaches logic.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         meta_r <= din;
         s2_r <= meta_r;
         s3_r <= s2_r;
      end
   end

   // Each bit updates only where the two later stages agree.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_r <= '0;
      end else begin
         out_r <= (s2_r & s3_r) | (out_r & (s2_r | s3_r));
      end
   end

   assign dout = out_r;

endmodule : input_sync
`default_nettype wire

//--- smps_comp_model.sv
// Behavioural comparator bank and extend pin ramp at the controller's far side.
`default_nettype none
module smps_comp_model
   import smps_ctrl_pkg::*;
#(
   parameter int RAMP_CYC = 30
) (
   input wire logic pclk,      // Timebase clock.
   input var int fdbk_mv,      // Feedback level in mV.
   input var int vcc_mv,       // Supply level in mV.
   input var int cs_mv,        // Current sense peak in mV.
   input wire logic hot,       // Junction above the trip level.
   input wire logic pull_low,  // Trigger transistor pulls the extend pin low.
   input wire logic clamp_rel, // Clamp switch released.
   output comp_s comp          // Comparator results.
);
   timeunit 1ns;
   timeprecision 1ps;
   int ramp = 0;
   // The pin charges only while the clamp is open, so a closed clamp restarts the ramp.
   always @(posedge pclk) ramp <= clamp_rel ? ramp + 1 : 0;
   // Plain thresholds; a real comparator chatters, this one does not.
   always_comb begin
      comp.fdbk_below_load = fdbk_mv < 1350;
      comp.fdbk_above_max = fdbk_mv > 4500;
      comp.ramp_done = ramp >= RAMP_CYC;
      comp.burst_wake = fdbk_mv > 3610;
      comp.burst_sleep = fdbk_mv <= 3000;
      comp.supply_over = vcc_mv > 24000;
      comp.winding_fault = cs_mv > 1660;
      comp.thermal_trip = hot;
      comp.latch_request = pull_low;
      comp.supply_below_on = vcc_mv < 10500;
      comp.supply_above_off = vcc_mv > 18000;
      comp.supply_below_reset = vcc_mv < 6230;
      comp.supply_under = vcc_mv < 10500;
   end
endmodule : smps_comp_model
`default_nettype wire

//--- smps_mode_ctrl_bench.sv
// Self-checking bench for the mode and protection controller.
`default_nettype none
module smps_mode_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import smps_ctrl_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic burst_flag, err, hot = 0, pl = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, v;
   int fdbk = 2000, vcc = 15000, cs = 500, miscompares = 0, tests_run = 0, cycles = 0;
   comp_s comp;
   drive_s drive;
   smps_mode_ctrl #(.BLANK_CYC(200), .SOFT_CYC(150), .LATCH_CYC(50)) dut_u (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp(comp),
      .drive(drive), .burst_flag(burst_flag));
   smps_comp_model cm_u (.pclk(pclk), .fdbk_mv(fdbk), .vcc_mv(vcc), .cs_mv(cs), .hot(hot),
      .pull_low(pl), .clamp_rel(drive.clamp_release), .comp(comp));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic chk(input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %0t ns: seen %h, expected %h", $time, s, e);
      end
   endtask : chk
   // One transfer; the request stands until pready is sampled high, a hang ends by timeout.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      chk(pready, 0);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic mode_is(input mode_e m);
      apb(0, STATUS_OFF, 0);
      chk(rd[2:0], m);
   endtask : mode_is
   // ----------------------------------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------------------------------
   initial begin
      forever #10 pclk = ~pclk;
   end
   // A hang counts as a mismatch and ends the run through the same report.
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   // Power up, burst, auto restart, each latch cause, then the register bus.
   initial begin
      void'($urandom(32'h6a23e5ad));
      cyc(20);
      presetn <= 1;
      cyc(3);
      chk(drive.startup_cell, 1);
      apb(0, CTRL_OFF, 0);
      chk(rd, 3);
      // A latch request held through power-up falls inside its blanking time.
      vcc <= 19000;
      pl <= 1;
      cyc(20);
      mode_is(ST_SOFT);
      pl <= 0;
      cyc(150);
      mode_is(ST_NORMAL);
      vcc <= 15000;
      fdbk <= 1000;
      cyc(170);
      mode_is(ST_NORMAL);
      cyc(50);
      mode_is(ST_BURST);
      chk({burst_flag, drive.bias_en, drive.startup_cell}, 3'b100);
      fdbk <= 3700;
      cyc(10);
      chk({drive.bias_en, drive.switch_en, drive.reduced_limit}, 3'b111);
      fdbk <= 2900;
      cyc(10);
      chk(drive.bias_en, 0);
      fdbk <= 4600;
      cyc(10);
      mode_is(ST_NORMAL);
      chk(drive.reduced_limit, 0);
      cyc(170);
      chk(drive.clamp_release, 0);
      cyc(40);
      chk(drive.clamp_release, 1);
      cyc(200);
      mode_is(ST_NORMAL);
      cyc(240);
      mode_is(ST_RESTART);
      chk({drive.switch_en, drive.startup_cell}, 2'b01);
      fdbk <= 2000;
      vcc <= 19000;
      cyc(170);
      mode_is(ST_NORMAL);
      hot <= 1;
      cyc(100);
      hot <= 0;
      vcc <= 25000;
      cyc(300);
      mode_is(ST_NORMAL);
      for (int k = 0; k < 4; k++) begin
         cs <= k == 0 ? 1700 : 500;
         vcc <= k == 1 ? 25000 : 15000;
         fdbk <= k == 1 ? 4600 : 2000;
         pl <= k == 2;
         hot <= k == 3;
         cyc(k == 0 ? 8 : 450);
         mode_is(ST_LATCHED);
         chk(drive.switch_en, 0);
         cs <= 500;
         fdbk <= 2000;
         pl <= 0;
         hot <= 0;
         vcc <= 10000;
         cyc(10);
         chk(drive.startup_cell, 1);
         vcc <= 19000;
         cyc(10);
         chk(drive.startup_cell, 0);
         mode_is(ST_LATCHED);
         vcc <= 6000;
         cyc(10);
         mode_is(ST_RESTART);
         vcc <= 19000;
         cyc(170);
         mode_is(ST_NORMAL);
         vcc <= 9000;
         cyc(10);
         mode_is(ST_RESTART);
         vcc <= 19000;
         cyc(170);
      end
      v = $urandom;
      apb(1, CTRL_OFF, v);
      apb(0, CTRL_OFF, 0);
      chk(rd, v & 32'h3);
      apb(0, 8'h08, 0);
      chk(err, 1);
      chk(rd, 0);
      report_and_stop();
   end
endmodule : smps_mode_ctrl_bench
`default_nettype wire
